// >>> hdl/fcdma_top.sv
// Four-channel DMA controller with Avalon-MM slave and master ports
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module fcdma_top (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // Avalon-MM register slave
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Peripheral requests, one per source slot, active high
    input  wire logic [3:0][4:0]       periph_request,
    // External request pins, active low, asynchronous
    input  wire logic                  ext_request_line_zero,
    input  wire logic                  ext_request_line_one,
    output logic      [1:0]            ext_dma_acknowledge_n,
    // Per-channel acknowledge and terminal interrupt
    output logic      [3:0]            chan_ack,
    output logic      [3:0]            chan_irq,
    // Shared bus master
    output fcdma_pkg::fcdma_mreq_s     mst_req,
    output logic                       mst_lock,
    input  wire logic                  mst_grant,
    input  wire logic                  mst_waitrequest,
    input  wire logic [31:0]           mst_readdata
);
    localparam int NC = fcdma_pkg::NUM_CH;

    logic [NC-1:0][31:0] src_reg, dst_reg, ctrl_reg, cur_src_reg, cur_dst_reg;
    logic [NC-1:0][1:0]  src_ctrl_reg, dst_ctrl_reg;
    logic [NC-1:0][19:0] tc_reg;
    logic [NC-1:0]       sw_req_reg, stop_reg;
    fcdma_pkg::fcdma_state_e [NC-1:0] st_reg;
    logic [1:0]          xs1_reg, xs2_reg;
    logic [1:0]          hs_wait_reg;
    logic [NC-1:0]       req_sel;
    logic [NC-1:0]       want_bus;

    // Atomic engine shared by all channels
    fcdma_pkg::fcdma_atom_e atom_reg;
    logic [1:0]          own_reg;
    logic [1:0]          beat_reg;
    logic [3:0][31:0]    buf_reg;
    logic                atom_done;

    // Decodes size field to byte step
    function automatic logic [31:0] size_step(input logic [1:0] sz);
        unique case (sz)
            2'd0:    size_step = 32'h0000_0001;
            2'd1:    size_step = 32'h0000_0002;
            default: size_step = 32'h0000_0004;
        endcase
    endfunction

    function automatic logic [2:0] beats_of(input logic [31:0] c);
        beats_of = c[fcdma_pkg::CTL_BURST] ? 3'(fcdma_pkg::BURST_LEN) : 3'd1;
    endfunction

    // Two-flop synchroniser on the active-low pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            xs1_reg <= 2'b11;
            xs2_reg <= 2'b11;
        end else begin
            xs1_reg <= {ext_request_line_one, ext_request_line_zero};
            xs2_reg <= xs1_reg; // see RULE_14
        end
    end

    // Request source selection
    always_comb begin
        for (int c = 0; c < NC; c++) begin
            logic [2:0] sel;
            logic       hw;
            sel = ctrl_reg[c][fcdma_pkg::CTL_SEL_LSB +: 3];
            hw = 1'b0;
            if (sel < 3'(fcdma_pkg::NUM_SRC)) begin
                hw = periph_request[c][sel]; // see RULE_04
            end
            if (c < 2 && sel == 3'd0) begin
                hw = ~xs2_reg[c];
            end
            // Source select ignored in software mode
            req_sel[c] = ctrl_reg[c][fcdma_pkg::CTL_HWSRC] ? hw : sw_req_reg[c]; // see RULE_02 see RULE_03
        end
    end

    // Channel main state machines
    generate
        for (genvar c = 0; c < NC; c++) begin : g_ch
            logic ext_mode;
            logic last;
            logic hs_hold;
            logic [31:0] step;
            assign ext_mode = (c < 2) && ctrl_reg[c][fcdma_pkg::CTL_HWSRC]
                              && ctrl_reg[c][fcdma_pkg::CTL_SEL_LSB +: 3] == 3'd0;
            assign last = (tc_reg[c] == 20'd1);
            // Pin still low from the last op must not start another
            assign hs_hold = ext_mode && hs_wait_reg[c % 2];
            assign step = size_step(ctrl_reg[c][fcdma_pkg::CTL_SIZE_LSB +: 2]) * 32'(beats_of(ctrl_reg[c]));
            assign want_bus[c] = (st_reg[c] == fcdma_pkg::FCDMA_XFER) && !hs_hold
                                 && (req_sel[c] || !ctrl_reg[c][fcdma_pkg::CTL_HWSRC] || !ctrl_reg[c][fcdma_pkg::CTL_WHOLE])
                                 && tc_reg[c] != 20'd0; // see RULE_17

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    st_reg[c] <= fcdma_pkg::FCDMA_IDLE;
                    tc_reg[c] <= 20'd0;
                    chan_ack[c] <= 1'b0;
                    chan_irq[c] <= 1'b0;
                    cur_src_reg[c] <= fcdma_pkg::RESET_VAL;
                    cur_dst_reg[c] <= fcdma_pkg::RESET_VAL;
                end else begin
                    unique case (st_reg[c])
                        fcdma_pkg::FCDMA_IDLE: begin
                            chan_ack[c] <= 1'b0; // see RULE_05
                            chan_irq[c] <= 1'b0;
                            if (req_sel[c] && !stop_reg[c] && !hs_hold
                                && ctrl_reg[c][fcdma_pkg::CTL_TC_MSB:0] != 20'd0) begin // see RULE_19
                                st_reg[c] <= fcdma_pkg::FCDMA_LOAD;
                            end
                        end
                        fcdma_pkg::FCDMA_LOAD: begin
                            chan_ack[c] <= 1'b1; // see RULE_06
                            if (tc_reg[c] == 20'd0) begin
                                tc_reg[c] <= ctrl_reg[c][fcdma_pkg::CTL_TC_MSB:0];
                                cur_src_reg[c] <= src_reg[c];
                                cur_dst_reg[c] <= dst_reg[c];
                            end
                            st_reg[c] <= fcdma_pkg::FCDMA_XFER;
                        end
                        fcdma_pkg::FCDMA_XFER: begin
                            if (atom_done && own_reg == 2'(c)) begin
                                tc_reg[c] <= tc_reg[c] - 20'd1; // see RULE_08
                                // Address update, fixed restores after a burst
                                if (!src_ctrl_reg[c][fcdma_pkg::INC_BIT]) begin // see RULE_23
                                    cur_src_reg[c] <= cur_src_reg[c] + step;
                                end
                                if (!dst_ctrl_reg[c][fcdma_pkg::INC_BIT]) begin
                                    cur_dst_reg[c] <= cur_dst_reg[c] + step;
                                end
                                if (last && ctrl_reg[c][fcdma_pkg::CTL_INTEN]) begin
                                    chan_irq[c] <= 1'b1; // see RULE_09
                                end
                                if (last || !ctrl_reg[c][fcdma_pkg::CTL_WHOLE]) begin
                                    chan_ack[c] <= 1'b0; // see RULE_10 see RULE_11
                                    st_reg[c] <= fcdma_pkg::FCDMA_IDLE;
                                end
                            end else if (stop_reg[c]) begin
                                chan_ack[c] <= 1'b0;
                                st_reg[c] <= fcdma_pkg::FCDMA_IDLE;
                            end
                            // Whole service stays here until count zero or a stop request, see RULE_12
                        end
                        default: st_reg[c] <= fcdma_pkg::FCDMA_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // Handshake hold: after a transfer, wait for pin release, see RULE_13
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hs_wait_reg <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (atom_done && own_reg == 2'(c) && ctrl_reg[c][fcdma_pkg::CTL_HSHAKE]) begin
                    hs_wait_reg[c] <= 1'b1; // see RULE_16
                end else if (xs2_reg[c]) begin
                    hs_wait_reg[c] <= 1'b0;
                end
            end
        end
    end

    // External acknowledge: active while channel acknowledges and, in handshake, until release
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_dma_acknowledge_n <= 2'b11;
        end else begin
            for (int c = 0; c < 2; c++) begin
                // Pin released seen at sync output drops ack next edge, see RULE_18
                ext_dma_acknowledge_n[c] <= !((chan_ack[c] && !(hs_wait_reg[c] && xs2_reg[c]))
                                              || (hs_wait_reg[c] && !xs2_reg[c])); // see RULE_15 see RULE_19
            end
        end
    end

    // Atomic sub-machine, fixed priority, bus locked across the chunk
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            atom_reg <= fcdma_pkg::FCDMA_A_IDLE;
            own_reg <= 2'd0;
            beat_reg <= 2'd0;
            buf_reg <= '0;
            mst_req <= '0;
            mst_lock <= 1'b0;
            atom_done <= 1'b0;
        end else begin
            atom_done <= 1'b0;
            unique case (atom_reg)
                fcdma_pkg::FCDMA_A_IDLE: begin
                    for (int c = NC - 1; c >= 0; c--) begin
                        if (want_bus[c]) begin
                            own_reg <= 2'(c); // see RULE_25
                        end
                    end
                    if (|want_bus) begin
                        atom_reg <= fcdma_pkg::FCDMA_A_REQ;
                        mst_lock <= 1'b1; // see RULE_22
                    end
                end
                fcdma_pkg::FCDMA_A_REQ: begin
                    if (mst_grant) begin
                        beat_reg <= 2'd0;
                        mst_req.read <= 1'b1;
                        mst_req.on_periph <= src_ctrl_reg[own_reg][fcdma_pkg::LOC_BIT]; // see RULE_01
                        mst_req.address <= cur_src_reg[own_reg];
                        mst_req.size <= ctrl_reg[own_reg][fcdma_pkg::CTL_SIZE_LSB +: 2];
                        atom_reg <= fcdma_pkg::FCDMA_A_RD; // see RULE_07
                    end
                end
                fcdma_pkg::FCDMA_A_RD: begin
                    if (!mst_waitrequest) begin
                        buf_reg[beat_reg] <= mst_readdata; // see RULE_24
                        if (3'(beat_reg) + 3'd1 == beats_of(ctrl_reg[own_reg])) begin
                            beat_reg <= 2'd0;
                            mst_req.read <= 1'b0;
                            mst_req.write <= 1'b1;
                            mst_req.on_periph <= dst_ctrl_reg[own_reg][fcdma_pkg::LOC_BIT];
                            mst_req.address <= cur_dst_reg[own_reg];
                            mst_req.writedata <= (beat_reg == 2'd0) ? mst_readdata : buf_reg[0];
                            atom_reg <= fcdma_pkg::FCDMA_A_WR;
                        end else begin
                            beat_reg <= beat_reg + 2'd1; // see RULE_20 see RULE_21
                            mst_req.address <= mst_req.address + size_step(mst_req.size);
                        end
                    end
                end
                fcdma_pkg::FCDMA_A_WR: begin
                    if (!mst_waitrequest) begin
                        if (3'(beat_reg) + 3'd1 == beats_of(ctrl_reg[own_reg])) begin
                            mst_req.write <= 1'b0;
                            atom_reg <= fcdma_pkg::FCDMA_A_DONE;
                        end else begin
                            beat_reg <= beat_reg + 2'd1;
                            mst_req.address <= mst_req.address + size_step(mst_req.size);
                            mst_req.writedata <= buf_reg[beat_reg + 2'd1];
                        end
                    end
                end
                fcdma_pkg::FCDMA_A_DONE: begin
                    mst_lock <= 1'b0;
                    atom_done <= 1'b1;
                    atom_reg <= fcdma_pkg::FCDMA_A_HOLD;
                end
                fcdma_pkg::FCDMA_A_HOLD: begin
                    // One settling cycle so channel state reflects the finished chunk
                    atom_reg <= fcdma_pkg::FCDMA_A_IDLE;
                end
                default: atom_reg <= fcdma_pkg::FCDMA_A_IDLE;
            endcase
        end
    end

    // Register slave, one wait cycle per access so read data comes from a flop
    logic       acc_reg;
    logic [1:0] ach;
    logic [5:0] aoff;
    assign ach = avs_address[7:6];
    assign aoff = avs_address[5:0];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_reg <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
            src_reg <= '0;
            dst_reg <= '0;
            ctrl_reg <= '0;
            src_ctrl_reg <= '0;
            dst_ctrl_reg <= '0;
            sw_req_reg <= '0;
            stop_reg <= '0;
        end else begin
            for (int c = 0; c < NC; c++) begin
                if (st_reg[c] == fcdma_pkg::FCDMA_LOAD) begin
                    sw_req_reg[c] <= 1'b0;
                end
                if (st_reg[c] == fcdma_pkg::FCDMA_IDLE) begin
                    stop_reg[c] <= 1'b0;
                end
            end
            avs_waitrequest <= 1'b1;
            acc_reg <= 1'b0;
            if ((avs_read || avs_write) && !acc_reg) begin
                acc_reg <= 1'b1;
                avs_waitrequest <= 1'b0;
                avs_readdata <= fcdma_pkg::UNMAPPED_VAL;
                if (avs_write) begin
                    unique case (aoff)
                        6'(fcdma_pkg::OFF_SRC):      src_reg[ach] <= {1'b0, avs_writedata[30:0]};
                        6'(fcdma_pkg::OFF_SRC_CTRL): src_ctrl_reg[ach] <= avs_writedata[1:0];
                        6'(fcdma_pkg::OFF_DST):      dst_reg[ach] <= {1'b0, avs_writedata[30:0]};
                        6'(fcdma_pkg::OFF_DST_CTRL): dst_ctrl_reg[ach] <= avs_writedata[1:0];
                        fcdma_pkg::OFF_CTRL:         ctrl_reg[ach] <= avs_writedata;
                        fcdma_pkg::OFF_TRIG: begin
                            sw_req_reg[ach] <= avs_writedata[fcdma_pkg::TRIG_SW];
                            stop_reg[ach] <= avs_writedata[fcdma_pkg::TRIG_STOP];
                        end
                        default: ;
                    endcase
                end else begin
                    unique case (aoff)
                        6'(fcdma_pkg::OFF_SRC):      avs_readdata <= src_reg[ach];
                        6'(fcdma_pkg::OFF_SRC_CTRL): avs_readdata <= {30'd0, src_ctrl_reg[ach]};
                        6'(fcdma_pkg::OFF_DST):      avs_readdata <= dst_reg[ach];
                        6'(fcdma_pkg::OFF_DST_CTRL): avs_readdata <= {30'd0, dst_ctrl_reg[ach]};
                        fcdma_pkg::OFF_CTRL:         avs_readdata <= ctrl_reg[ach];
                        fcdma_pkg::OFF_STAT:         avs_readdata <= {8'd0, chan_irq[ach], chan_ack[ach],
                                                                      st_reg[ach], tc_reg[ach]};
                        fcdma_pkg::OFF_CUR_SRC:      avs_readdata <= cur_src_reg[ach];
                        fcdma_pkg::OFF_CUR_DST:      avs_readdata <= cur_dst_reg[ach];
                        default: ;
                    endcase
                end
            end
        end
    end
endmodule

// >>> include/fcdma_pkg.sv
// Package of constants and types for the four-channel DMA controller
//
// Operation
// RULE_01: Four channels, any bus to any bus
// RULE_02: Start by software, peripheral or pin
// RULE_03: Hardware mode uses one selected source
// RULE_04: Fixed five-entry source table per channel
// RULE_05: Idle waits, acknowledge and interrupt low
// RULE_06: Load raises acknowledge, loads count field
// RULE_07: Atomic read then write, repeat per service
// RULE_08: Count decrements per completed atomic operation
// RULE_09: Interrupt at count zero when enabled
// RULE_10: Acknowledge clears at zero or single end
// RULE_11: Single service returns idle each operation
// RULE_12: Whole service stays until count zero
// RULE_13: Demand and handshake external protocols supported
// RULE_14: External request synchronised twice first
// RULE_15: Acknowledge, then bus request, then transfer
// RULE_16: Sample synced request after each transfer
// RULE_17: Demand: continue while request still asserted
// RULE_18: Handshake: drop acknowledge within two cycles
// RULE_19: Requester asserts only after acknowledge high
// RULE_20: Burst four does four reads, four writes
// RULE_21: Unit does one read, one write
// RULE_22: Bus locked during each chunk
// RULE_23: Increment or fixed address, burst restores
// RULE_24: Burst reads buffered before writes
// RULE_25: Lowest channel wins bus arbitration
package fcdma_pkg;
    localparam int NUM_CH = 4;
    localparam int NUM_SRC = 5;
    localparam int BURST_LEN = 4;
    // Offsets inside a channel window
    localparam logic [7:0] CH_STRIDE = 8'h40;
    localparam logic [3:0] OFF_SRC = 4'h0;
    localparam logic [3:0] OFF_SRC_CTRL = 4'h4;
    localparam logic [3:0] OFF_DST = 4'h8;
    localparam logic [3:0] OFF_DST_CTRL = 4'hC;
    localparam logic [5:0] OFF_CTRL = 6'h10;
    localparam logic [5:0] OFF_STAT = 6'h14;
    localparam logic [5:0] OFF_CUR_SRC = 6'h18;
    localparam logic [5:0] OFF_CUR_DST = 6'h1C;
    localparam logic [5:0] OFF_TRIG = 6'h20;
    // Control word fields
    localparam int CTL_TC_MSB = 19;
    localparam int CTL_SIZE_LSB = 20;
    localparam int CTL_SEL_LSB = 24;
    localparam int CTL_HWSRC = 27;
    localparam int CTL_BURST = 28;
    localparam int CTL_INTEN = 29;
    localparam int CTL_WHOLE = 30;
    localparam int CTL_HSHAKE = 31;
    localparam int LOC_BIT = 1;
    localparam int INC_BIT = 0;
    localparam int TRIG_SW = 0;
    localparam int TRIG_STOP = 1;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;

    typedef enum logic [1:0] {FCDMA_IDLE, FCDMA_LOAD, FCDMA_XFER} fcdma_state_e;
    typedef enum logic [2:0] {FCDMA_A_IDLE, FCDMA_A_REQ, FCDMA_A_RD, FCDMA_A_WR, FCDMA_A_DONE, FCDMA_A_HOLD}
        fcdma_atom_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic        on_periph;
        logic [31:0] address;
        logic [31:0] writedata;
        logic [1:0]  size;
    } fcdma_mreq_s;
endpackage

// >>> verification/fcdma_assertions.sv
// Pin-level checks on the DMA controller
`timescale 1ns/100ps
module fcdma_assertions (
    // Clock and reset
    input wire logic                   sys_clk,
    input wire logic                   rst,
    // Watched pins
    input wire logic                   ext_request_line_zero,
    input wire logic [1:0]             ext_dma_acknowledge_n,
    input wire logic [3:0]             chan_ack,
    input wire logic [3:0]             chan_irq,
    input wire fcdma_pkg::fcdma_mreq_s mst_req,
    input wire logic                   mst_lock,
    input wire logic                   mst_waitrequest
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [3:0] rd_cnt;
    logic [3:0] wr_cnt;
    // Beats accepted inside one locked chunk
    always_ff @(posedge sys_clk) begin
        if (rst || !mst_lock) begin
            rd_cnt <= 4'h0;
            wr_cnt <= 4'h0;
        end else if (!mst_waitrequest) begin
            rd_cnt <= rd_cnt + 4'(mst_req.read);
            wr_cnt <= wr_cnt + 4'(mst_req.write);
        end
    end
    reset_quiet_a: assert property ($fell(rst) |-> chan_ack == 4'h0 && chan_irq == 4'h0)
        else $error("not quiet after reset");
    irq_after_ack_a: assert property ((chan_irq & ~$past(chan_irq) & ~$past(chan_ack)) == 4'h0)
        else $error("irq without ack");
    ack_two_sync_a: assert property ($fell(ext_dma_acknowledge_n[0]) |-> !$past(ext_request_line_zero, 2))
        else $error("ack before sync");
    hs_release_a: assert property
        ((ext_request_line_zero [*3] ##0 !chan_ack[0]) |-> ##[0:2] ext_dma_acknowledge_n[0])
        else $error("ack not released");
    lock_on_access_a: assert property ((mst_req.read || mst_req.write) |-> mst_lock)
        else $error("bus access without lock");
    lock_by_chan_a: assert property ($rose(mst_lock) |-> chan_ack != 4'h0)
        else $error("lock without ack");
    req_held_a: assert property ((mst_req.read || mst_req.write) && mst_waitrequest |=> $stable(mst_req))
        else $error("request not held");
    chunk_size_a: assert property
        ($fell(mst_lock) |-> rd_cnt == wr_cnt && (rd_cnt == 4'h1 || rd_cnt == 4'h4))
        else $error("bad beat count");
    write_after_reads_a: assert property
        (mst_req.write |-> rd_cnt > wr_cnt && (rd_cnt == 4'h1 || rd_cnt == 4'h4))
        else $error("write before reads");
endmodule
bind fcdma_top fcdma_assertions fcdma_assertions_i (.*);

// >>> verification/fcdma_mem_model.sv
// Bus memory and arbiter facing the DMA master port
`timescale 1ns/100ps
module fcdma_mem_model (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Master port of the controller
    input  wire fcdma_pkg::fcdma_mreq_s mst_req,
    input  wire logic                   mst_lock,
    output logic                        mst_grant,
    output logic                        mst_waitrequest,
    output logic [31:0]                 mst_readdata,
    // Answer delay and write log
    input  wire logic [3:0]             stall,
    output logic [31:0]                 wr_addr,
    output logic [31:0]                 wr_data,
    output logic [7:0]                  wr_cnt
);
    logic [3:0] dly_reg;
    // No rival master, so grant trails lock by one cycle
    always_ff @(posedge sys_clk) begin
        mst_grant <= mst_lock && !rst;
    end
    // Stale read data toggles so it never looks valid
    always_ff @(posedge sys_clk) begin
        mst_readdata <= ~mst_readdata;
        if (rst) begin
            mst_waitrequest <= 1'b1;
            mst_readdata <= 32'h0000_0000;
            dly_reg <= 4'h0;
            wr_cnt <= 8'h00;
        end else if (!mst_waitrequest) begin
            mst_waitrequest <= 1'b1;
            dly_reg <= 4'h0;
            if (mst_req.write) begin
                wr_cnt <= wr_cnt + 8'h01;
                wr_addr <= mst_req.address;
                wr_data <= mst_req.writedata;
            end
        end else if (mst_grant && (mst_req.read || mst_req.write)) begin
            dly_reg <= dly_reg + 4'h1;
            if (dly_reg == stall) begin
                mst_waitrequest <= 1'b0;
                mst_readdata <= {mst_req.address[15:0], ~mst_req.address[15:0]};
            end
        end
    end
endmodule

// >>> verification/fcdma_bench.sv
// Self-checking bench of the DMA controller
`timescale 1ns/100ps
module fcdma_bench;
    logic                   sys_clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [7:0]             avs_address = 8'h00, wr_cnt, n0;
    logic [31:0]            avs_writedata = 32'h0000_0000, avs_readdata, q, wr_addr, wr_data;
    logic [3:0][4:0]        periph_request = 20'h0_0000;
    logic                   ext_request_line_zero = 1'b1, ext_request_line_one = 1'b1;
    logic [1:0]             ext_dma_acknowledge_n;
    logic [3:0]             chan_ack, chan_irq, irq_seen, stall = 4'h0;
    fcdma_pkg::fcdma_mreq_s mst_req;
    logic                   mst_lock, mst_grant, mst_waitrequest;
    logic [31:0]            mst_readdata;
    int                     error_cnt = 0, n_compared = 0, cycles = 0;
    fcdma_top fcdma_top_i (.*);
    fcdma_mem_model fcdma_mem_model_i (.*);
    initial forever #5 sys_clk = ~sys_clk;
    function automatic logic [31:0] src(input int ch);
        return {16'h0000, 4'(ch), 12'h100};
    endfunction
    function automatic logic [31:0] dst(input int ch);
        return {16'h0000, 4'(ch), 12'h800};
    endfunction
    // Word the memory model returns for a read address
    function automatic logic [31:0] rdv(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    function automatic logic [7:0] ra(input int ch, input logic [5:0] off);
        return {2'(ch), off};
    endfunction
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Hang guard, run needs a few hundred cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic setup(input int ch, input logic [31:0] sctl, input logic [31:0] ctl);
        bus(1'b1, ra(ch, fcdma_pkg::OFF_SRC), src(ch));
        bus(1'b1, ra(ch, fcdma_pkg::OFF_SRC_CTRL), sctl);
        bus(1'b1, ra(ch, fcdma_pkg::OFF_DST), dst(ch));
        bus(1'b1, ra(ch, fcdma_pkg::OFF_DST_CTRL), sctl);
        bus(1'b1, ra(ch, fcdma_pkg::OFF_CTRL), ctl);
        n0 = wr_cnt;
    endtask
    task automatic wait_hi(input int ch);
        irq_seen = 4'h0;
        while (chan_ack[ch] !== 1'b1) @(posedge sys_clk);
    endtask
    // Interrupt is about one cycle wide, so collect it
    task automatic wait_lo(input int ch);
        while (chan_ack[ch] !== 1'b0) begin
            @(posedge sys_clk);
            irq_seen |= chan_irq;
        end
        repeat (3) begin
            @(posedge sys_clk);
            irq_seen |= chan_irq;
        end
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        chk(chan_ack, 32'h0000_0000);
        chk(ext_dma_acknowledge_n, 32'h0000_0003);
        bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
        bus(1'b0, 8'h3C, 32'h0000_0000);
        chk(q, fcdma_pkg::UNMAPPED_VAL);
        bus(1'b0, ra(2, fcdma_pkg::OFF_STAT), 32'h0000_0000);
        chk(q, fcdma_pkg::RESET_VAL);
        $display("reset test done");
        setup(2, 32'h0000_0000, 32'h6020_0003);
        bus(1'b1, ra(2, fcdma_pkg::OFF_TRIG), 32'h0000_0001);
        wait_hi(2);
        wait_lo(2);
        chk(wr_cnt - n0, 32'h0000_0003);
        chk(wr_addr, dst(2) + 32'h0000_0008);
        chk(wr_data, rdv(src(2) + 32'h0000_0008));
        chk(irq_seen[2], 32'h0000_0001);
        $display("whole service test done");
        stall <= 4'h3;
        setup(3, 32'h0000_0001, 32'h1020_0002);
        for (int k = 1; k >= 0; k--) begin
            n0 = wr_cnt;
            bus(1'b1, ra(3, fcdma_pkg::OFF_TRIG), 32'h0000_0001);
            wait_hi(3);
            wait_lo(3);
            chk(wr_cnt - n0, 32'h0000_0004);
            chk(wr_addr, dst(3) + 32'h0000_000C);
            chk(wr_data, rdv(src(3) + 32'h0000_000C));
            bus(1'b0, ra(3, fcdma_pkg::OFF_STAT), 32'h0000_0000);
            chk(q[19:0], 32'(k));
            chk(irq_seen[3], 32'h0000_0000);
        end
        $display("burst fixed test done");
        setup(1, 32'h0000_0000, 32'h2820_0002);
        ext_request_line_one <= 1'b0;
        wait_hi(1);
        wait_lo(1);
        wait_hi(1);
        ext_request_line_one <= 1'b1;
        wait_lo(1);
        chk(wr_cnt - n0, 32'h0000_0002);
        chk(irq_seen[1], 32'h0000_0001);
        $display("demand test done");
        setup(0, 32'h0000_0000, 32'hA820_0001);
        ext_request_line_zero <= 1'b0;
        wait_hi(0);
        wait_lo(0);
        repeat (4) @(posedge sys_clk);
        chk(ext_dma_acknowledge_n[0], 32'h0000_0000);
        ext_request_line_zero <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk(ext_dma_acknowledge_n[0], 32'h0000_0001);
        chk(wr_cnt - n0, 32'h0000_0001);
        $display("handshake test done");
        setup(3, 32'h0000_0000, 32'h6A20_0001);
        periph_request[3] <= 5'b00010;
        repeat (20) @(posedge sys_clk);
        chk(chan_ack[3], 32'h0000_0000);
        periph_request[3] <= 5'b00100;
        wait_hi(3);
        wait_lo(3);
        periph_request[3] <= 5'b00000;
        chk(wr_cnt - n0, 32'h0000_0001);
        $display("peripheral test done");
        report_and_stop();
    end
endmodule
